// file: core/wfp_top.sv
// The register offsets and register access over Wishbone are this design's own decisions.
`include "wfp_defines.svh"
module wfp_top (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // Wakeup pins, active low
  input wire logic [7:0] wakeup_pin_n_i,
  output logic wake_request_o,
  // CPU power-mode control
  input wire wfp_pkg::wfp_pmode_type power_mode_i,
  input wire logic sleep_exec_i,
  input wire logic direct_transfer_i,
  output logic direct_transfer_enable_o,
  // Port with pull-up exception
  input wire logic [7:0] pu_port_i,
  output logic [7:0] pu_port_o,
  output logic [7:0] pu_port_oe_o,
  output logic [7:0] pu_port_pullup_o,
  // Plain port
  input wire logic [7:0] plain_port_i,
  output logic [7:0] plain_port_o,
  output logic [7:0] plain_port_oe_o,
  output logic [7:0] plain_port_pullup_o,
  // Analog-capable port
  input wire logic [7:0] ana_port_i,
  output logic [7:0] ana_port_o,
  output logic [7:0] ana_port_oe_o,
  output logic [7:0] ana_port_pullup_o
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wfp_pkg::wfp_wb_req_type req;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic bus_req;
  logic wr_fire;
  logic lane0;
  logic [7:0] wdat;
  logic [3:0] blk;
  logic [3:0] sub;
  logic port_hit;
  logic [1:0] port_idx;

  logic [7:0] wake_req_ff;
  logic [7:0] wake_cfg_ff;
  logic dte_ff;
  logic dt_flag_ff;
  logic [8:0] int_stat_ff;
  logic [8:0] int_en_ff;

  logic [7:0] wake_fall;
  logic [7:0] wake_set;
  logic [7:0] wake_clr;
  logic dt_set;
  logic dt_clr;
  logic [8:0] int_evt;
  logic [8:0] int_clr;

  logic [7:0] port_data_ff [0:2];
  logic [7:0] port_dir_ff [0:2];
  logic [7:0] port_pu_ff [0:2];
  logic [7:0] port_level [0:2];
  wfp_pkg::wfp_pin_type port_drv [0:2];
  logic [7:0] port_pull [0:2];

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Bundle the request so decode reads one carrier
  assign req.adr = wb_adr_i;
  assign req.dat = wb_dat_i;
  assign req.sel = wb_sel_i;
  assign req.we = wb_we_i;

  assign bus_req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master samples ack
  assign wr_fire = bus_req & ack_ff & req.we;
  // Registers are 8 bits wide, so lane 0 carries data; only interrupt bit 8 rides lane 1
  assign lane0 = req.sel[0];
  assign wdat = req.dat[7:0];
  assign blk = req.adr[7:4];
  assign sub = req.adr[3:0];
  assign port_hit = (blk >= `WFP_PORT_BLK_FIRST) && (blk <= `WFP_PORT_BLK_LAST);
  assign port_idx = 2'(blk - `WFP_PORT_BLK_FIRST);

  // Ack one cycle after the strobe, dropped the cycle after; unmapped answers zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  // Read mux, captured together with ack so data is stable while ack is high
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (port_hit) begin
      case (sub)
        `WFP_PORT_DATA: nxt_rdata[7:0] = port_data_ff[port_idx];
        `WFP_PORT_DIR: nxt_rdata[7:0] = port_dir_ff[port_idx];
        `WFP_PORT_PU: nxt_rdata[7:0] = port_pu_ff[port_idx];
        `WFP_PORT_PIN: nxt_rdata[7:0] = port_level[port_idx];
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end else begin
      case (req.adr)
        `WFP_OFS_WAKE_REQ: nxt_rdata[7:0] = wake_req_ff; // [RULE5]
        `WFP_OFS_WAKE_CFG: nxt_rdata[7:0] = wake_cfg_ff;
        `WFP_OFS_SYS_CTRL: nxt_rdata[`WFP_CTRL_DTE_BIT] = dte_ff;
        `WFP_OFS_DT_FLAG: nxt_rdata[`WFP_DT_FLAG_BIT] = dt_flag_ff;
        `WFP_OFS_INT_STAT: nxt_rdata[8:0] = int_stat_ff;
        `WFP_OFS_INT_EN: nxt_rdata[8:0] = int_en_ff;
        `WFP_OFS_PMODE: nxt_rdata[2:0] = power_mode_i;
        // The clear register is write-only and reads zero
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (bus_req & ~ack_ff & ~req.we) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // ----------------------------------------------------------------
  // Wakeup request flags
  // ----------------------------------------------------------------
  wfp_edge_sync u_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_n_i(wakeup_pin_n_i),
    .fall_o(wake_fall)
  );

  // Only pins configured as interrupt inputs may raise a flag
  assign wake_set = wake_fall & wake_cfg_ff; // [RULE2]
  // A written 0 clears, a written 1 is ignored
  assign wake_clr = (wr_fire && lane0 && (req.adr == `WFP_OFS_WAKE_REQ)) ? ~wdat : 8'h00; // [RULE4]

  // Set beats clear so an edge in the clearing cycle is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_req_ff <= `WFP_WAKE_RST; // [RULE5]
    end else begin
      wake_req_ff <= (wake_req_ff & ~wake_clr) | wake_set; // [RULE3] [RULE2]
    end
  end

  // Interrupt-input configuration of each wakeup pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_cfg_ff <= `WFP_BYTE_RST;
    end else if (wr_fire && lane0 && (req.adr == `WFP_OFS_WAKE_CFG)) begin
      wake_cfg_ff <= wdat;
    end
  end

  // Wake the CPU while any flag of a configured pin stands
  assign wake_request_o = |(wake_req_ff & wake_cfg_ff);

  // ----------------------------------------------------------------
  // Direct transfer control and flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dte_ff <= 1'b0;
    end else if (wr_fire && lane0 && (req.adr == `WFP_OFS_SYS_CTRL)) begin
      dte_ff <= wdat[`WFP_CTRL_DTE_BIT];
    end
  end

  assign direct_transfer_enable_o = dte_ff;
  // Needs all three at once: sleep executed, enabled, transfer made
  assign dt_set = sleep_exec_i & dte_ff & direct_transfer_i; // [RULE1]
  // Same write-zero-to-clear convention as the wakeup flags
  assign dt_clr = wr_fire && lane0 && (req.adr == `WFP_OFS_DT_FLAG) &&
                  !wdat[`WFP_DT_FLAG_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dt_flag_ff <= 1'b0;
    end else begin
      dt_flag_ff <= (dt_flag_ff & ~dt_clr) | dt_set; // [RULE1]
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, clear and enable
  // ----------------------------------------------------------------
  assign int_evt = {dt_set, wake_set};
  // The clear register takes 1s; lane 1 holds bit 8
  always_comb begin
    int_clr = 9'h000;
    if (wr_fire && (req.adr == `WFP_OFS_INT_CLR)) begin
      if (req.sel[0]) begin
        int_clr[7:0] = wdat;
      end
      if (req.sel[1]) begin
        int_clr[`WFP_INT_DT_BIT] = req.dat[`WFP_INT_DT_BIT];
      end
    end
  end

  // Sticky; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_stat_ff <= `WFP_INT_RST;
    end else begin
      int_stat_ff <= (int_stat_ff & ~int_clr) | int_evt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_en_ff <= `WFP_INT_RST;
    end else if (wr_fire && (req.adr == `WFP_OFS_INT_EN)) begin
      if (req.sel[0]) begin
        int_en_ff[7:0] <= wdat;
      end
      if (req.sel[1]) begin
        int_en_ff[`WFP_INT_DT_BIT] <= req.dat[`WFP_INT_DT_BIT];
      end
    end
  end

  // Level output, high while any enabled status bit is set
  assign irq_o = |(int_stat_ff & int_en_ff);

  // ----------------------------------------------------------------
  // Port registers
  // ----------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_port
      logic hit;
      assign hit = wr_fire && lane0 && port_hit && (port_idx == 2'(p));
      // Data, direction and pull-up select, one always_ff per port
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          port_data_ff[p] <= `WFP_BYTE_RST;
          port_dir_ff[p] <= `WFP_BYTE_RST;
          port_pu_ff[p] <= `WFP_BYTE_RST;
        end else if (hit) begin
          case (sub)
            `WFP_PORT_DATA: port_data_ff[p] <= wdat;
            `WFP_PORT_DIR: port_dir_ff[p] <= wdat;
            `WFP_PORT_PU: port_pu_ff[p] <= wdat;
            default: port_data_ff[p] <= port_data_ff[p];
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Port pin drivers per power state
  // ----------------------------------------------------------------
  wfp_port_ctrl #(
    .KIND(wfp_pkg::PK_PULLUP_EXC)
  ) u_pu_port (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pmode_i(power_mode_i),
    .data_i(port_data_ff[0]),
    .dir_i(port_dir_ff[0]),
    .pu_i(port_pu_ff[0]),
    .pin_i(pu_port_i),
    .drive_o(port_drv[0]), // [RULE7]
    .pullup_o(port_pull[0]),
    .level_o(port_level[0])
  );

  wfp_port_ctrl #(
    .KIND(wfp_pkg::PK_PLAIN)
  ) u_plain_port (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pmode_i(power_mode_i),
    .data_i(port_data_ff[1]),
    .dir_i(port_dir_ff[1]),
    .pu_i(port_pu_ff[1]),
    .pin_i(plain_port_i),
    .drive_o(port_drv[1]),
    .pullup_o(port_pull[1]),
    .level_o(port_level[1])
  );

  // Floats in standby and subactive as well as in reset
  wfp_port_ctrl #(
    .KIND(wfp_pkg::PK_ANALOG)
  ) u_ana_port (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pmode_i(power_mode_i),
    .data_i(port_data_ff[2]),
    .dir_i(port_dir_ff[2]),
    .pu_i(port_pu_ff[2]),
    .pin_i(ana_port_i),
    .drive_o(port_drv[2]), // [RULE6]
    .pullup_o(port_pull[2]),
    .level_o(port_level[2])
  );

  // Pin outputs straight from the driver flops; the pull-up enables are combinational from the power mode
  assign pu_port_o = port_drv[0].out;
  assign pu_port_oe_o = port_drv[0].oe;
  assign pu_port_pullup_o = port_pull[0];
  assign plain_port_o = port_drv[1].out;
  assign plain_port_oe_o = port_drv[1].oe;
  assign plain_port_pullup_o = port_pull[1];
  assign ana_port_o = port_drv[2].out;
  assign ana_port_oe_o = port_drv[2].oe;
  assign ana_port_pullup_o = port_pull[2];
endmodule

// file: core/wfp_defines.svh
`ifndef WFP_DEFINES_SVH
`define WFP_DEFINES_SVH
// Operation
// RULE1: Sleep executed with direct transfer enabled and a transfer made sets the transfer flag.
// RULE2: A falling edge on an interrupt-configured wakeup pin sets that pin's flag.
// RULE3: Writing 0 to a set wakeup flag clears it.
// RULE4: Writing 1 to a wakeup flag leaves it unchanged; writes only clear.
// RULE5: Eight independent wakeup flags, bits 7 to 0, all zero after reset.
// RULE6: Pins float in reset, hold in sleep, work when active; analog ports float more.
// RULE7: In standby, pull-up exception ports drive high while their MOS pull-up is on.
// RULE8: Wakeup pins are synchronised before edge detection, so one edge sets once.

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define WFP_OFS_WAKE_REQ 8'h00
`define WFP_OFS_WAKE_CFG 8'h04
`define WFP_OFS_SYS_CTRL 8'h08
`define WFP_OFS_DT_FLAG 8'h0C
`define WFP_OFS_INT_STAT 8'h10
`define WFP_OFS_INT_CLR 8'h14
`define WFP_OFS_INT_EN 8'h18
`define WFP_OFS_PMODE 8'h1C
// Port blocks: base 0x20, 0x30, 0x40; data, direction, pull-up, pin level
`define WFP_PORT_BLK_FIRST 4'h2
`define WFP_PORT_BLK_LAST 4'h4
`define WFP_PORT_DATA 4'h0
`define WFP_PORT_DIR 4'h4
`define WFP_PORT_PU 4'h8
`define WFP_PORT_PIN 4'hC

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define WFP_CTRL_DTE_BIT 0
`define WFP_DT_FLAG_BIT 0
`define WFP_INT_DT_BIT 8
`define WFP_WAKE_RST 8'h00
`define WFP_BYTE_RST 8'h00
`define WFP_INT_RST 9'h000
`define WFP_SYNC_STAGES 2
`endif

// file: core/wfp_pkg.sv
package wfp_pkg;
  // Power states reported by the CPU power-mode control
  typedef enum logic [2:0] {
    PM_ACTIVE,
    PM_SUBACTIVE,
    PM_SLEEP,
    PM_SUBSLEEP,
    PM_WATCH,
    PM_STANDBY
  } wfp_pmode_type;

  // Port flavours, differing only in low-power behaviour
  typedef enum logic [1:0] {
    PK_PULLUP_EXC,
    PK_PLAIN,
    PK_ANALOG
  } wfp_port_kind_type;

  // One Wishbone request as seen by the slave
  typedef struct packed {
    logic [7:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
  } wfp_wb_req_type;

  // Drive of an 8-bit port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } wfp_pin_type;
endpackage

// file: core/wfp_edge_sync.sv
`include "wfp_defines.svh"
module wfp_edge_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] pin_n_i,
  output logic [7:0] fall_o
);
  // ----------------------------------------------------------------
  // Per-pin synchroniser and falling-edge detector
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      logic [`WFP_SYNC_STAGES-1:0] sync_ff;
      logic last_ff;
      // Two flops against metastability; only the second is looked at
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync_ff <= '1;
        end else begin
          sync_ff <= {sync_ff[0], pin_n_i[g]}; // [RULE8]
        end
      end
      // Previous synced level; idle high so reset release gives no edge
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          last_ff <= 1'b1;
        end else begin
          last_ff <= sync_ff[1];
        end
      end
      // One-cycle pulse per falling edge
      assign fall_o[g] = last_ff & ~sync_ff[1]; // [RULE8]
    end
  endgenerate
endmodule

// file: core/wfp_port_ctrl.sv
`include "wfp_defines.svh"
module wfp_port_ctrl #(
  parameter wfp_pkg::wfp_port_kind_type KIND = wfp_pkg::PK_PLAIN
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire wfp_pkg::wfp_pmode_type pmode_i,
  input wire logic [7:0] data_i,
  input wire logic [7:0] dir_i,
  input wire logic [7:0] pu_i,
  input wire logic [7:0] pin_i,
  output wfp_pkg::wfp_pin_type drive_o,
  output logic [7:0] pullup_o,
  output logic [7:0] level_o
);
  wfp_pkg::wfp_pin_type drv_ff;
  wfp_pkg::wfp_pin_type nxt_drv;
  logic [7:0] pin_s1_ff;
  logic [7:0] level_ff;
  logic active_fn;

  // Analog-capable ports do not work in subactive
  assign active_fn = (pmode_i == wfp_pkg::PM_ACTIVE) ||
                     ((pmode_i == wfp_pkg::PM_SUBACTIVE) && (KIND != wfp_pkg::PK_ANALOG));

  // ----------------------------------------------------------------
  // Drive selection per power state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_drv = drv_ff;
    case (pmode_i)
      wfp_pkg::PM_ACTIVE, wfp_pkg::PM_SUBACTIVE: begin
        if (active_fn) begin
          nxt_drv.out = data_i; // [RULE6]
          nxt_drv.oe = dir_i;
        end else begin
          nxt_drv = '0; // [RULE6]
        end
      end
      wfp_pkg::PM_SLEEP, wfp_pkg::PM_SUBSLEEP, wfp_pkg::PM_WATCH: begin
        nxt_drv = drv_ff; // [RULE6]
      end
      wfp_pkg::PM_STANDBY: begin
        if (KIND == wfp_pkg::PK_PULLUP_EXC) begin
          nxt_drv.out = pu_i; // [RULE7]
          nxt_drv.oe = pu_i;
        end else begin
          nxt_drv = '0; // [RULE6]
        end
      end
      default: begin
        nxt_drv = '0;
      end
    endcase
  end

  // Pins float during reset and the retained value lives here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drv_ff <= '0; // [RULE6]
    end else begin
      drv_ff <= nxt_drv;
    end
  end

  // Pin levels come from outside: two flops before software sees them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_ff <= `WFP_BYTE_RST;
      level_ff <= `WFP_BYTE_RST;
    end else begin
      pin_s1_ff <= pin_i;
      level_ff <= pin_s1_ff;
    end
  end

  assign drive_o = drv_ff;
  assign level_o = level_ff;
  // MOS pull-up only on inputs while the port functions
  assign pullup_o = active_fn ? (pu_i & ~dir_i) : 8'h00;
endmodule

// file: verification/wfp_top_monitor.sv
module wfp_top_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wake_request_o,
  input wire wfp_pkg::wfp_pmode_type power_mode_i,
  input wire logic [7:0] pu_port_o,
  input wire logic [7:0] pu_port_oe_o,
  input wire logic [7:0] plain_port_o,
  input wire logic [7:0] plain_port_oe_o,
  input wire logic [7:0] ana_port_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ---------------------------------------------
  // Bus handshake and pin states
  // ---------------------------------------------
  sequence req_s;
    $rose(wb_stb_i);
  endsequence
  sequence ack_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_pulse_a: assert property (req_s |=> ack_s) else $error("ack not a single pulse");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:9] == 23'h0)
    else $error("upper read bits set");
  rst_float_a: assert property ($fell(rst_i) |-> (pu_port_oe_o | plain_port_oe_o
    | ana_port_oe_o) == 8'h00) else $error("pin driven in reset");
  standby_float_a: assert property ($past(power_mode_i) == wfp_pkg::PM_STANDBY
    |-> (plain_port_oe_o | ana_port_oe_o) == 8'h00) else $error("pin driven in standby");
  subact_analog_a: assert property ($past(power_mode_i) == wfp_pkg::PM_SUBACTIVE
    |-> ana_port_oe_o == 8'h00) else $error("analog port driven in subactive");
  standby_pullup_a: assert property ($past(power_mode_i) == wfp_pkg::PM_STANDBY
    |-> (pu_port_o & pu_port_oe_o) == pu_port_oe_o) else $error("standby drive not high");
  sleep_hold_a: assert property (power_mode_i == wfp_pkg::PM_SLEEP
    && $past(power_mode_i) == wfp_pkg::PM_SLEEP |=> $stable(plain_port_o)
    && $stable(plain_port_oe_o)) else $error("port changed in sleep");
  // Only a bus write may take a request away
  wake_clear_a: assert property ($fell(wake_request_o) |-> $past(wb_ack_o && wb_we_i))
    else $error("wake request dropped without write");
endmodule
bind wfp_top wfp_top_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wake_request_o(wake_request_o), .power_mode_i(power_mode_i), .pu_port_o(pu_port_o),
  .pu_port_oe_o(pu_port_oe_o), .plain_port_o(plain_port_o),
  .plain_port_oe_o(plain_port_oe_o), .ana_port_oe_o(ana_port_oe_o));

// file: verification/wfp_wake_pins.sv
module wfp_wake_pins (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] fire_i,
  input wire logic [2:0] hold_i,
  output logic [7:0] pin_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] left_ff;
  // Pulled-up lines: low for hold_i cycles, then released back high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_n_o <= 8'hFF;
      left_ff <= 3'h0;
    end else if (fire_i != 8'h00) begin
      pin_n_o <= ~fire_i;
      left_ff <= hold_i;
    end else if (left_ff != 3'h0) begin
      left_ff <= left_ff - 3'h1;
      if (left_ff == 3'h1) pin_n_o <= 8'hFF;
    end
  end
endmodule

// file: verification/wfp_top_bench.sv
module wfp_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, cyc, stb, we, slp, dtm, ack, irq, wreq, dte;
  logic [3:0] sel;
  logic [2:0] hold;
  logic [7:0] adr, fire, pins_n, m, w, d, r, p, pu_o, pu_oe, pu_pu;
  logic [7:0] pl_o, pl_oe, pl_pu, an_o, an_oe, an_pu;
  logic [31:0] wdat, rd, seed, dat_o;
  logic [23:0] pins;
  wfp_pkg::wfp_pmode_type pm;
  int miscompares, cmp_count;
  wfp_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .irq_o(irq), .wakeup_pin_n_i(pins_n), .wake_request_o(wreq), .power_mode_i(pm),
    .sleep_exec_i(slp), .direct_transfer_i(dtm), .direct_transfer_enable_o(dte),
    .pu_port_i(pins[7:0]), .pu_port_o(pu_o), .pu_port_oe_o(pu_oe), .pu_port_pullup_o(pu_pu),
    .plain_port_i(pins[15:8]), .plain_port_o(pl_o), .plain_port_oe_o(pl_oe),
    .plain_port_pullup_o(pl_pu), .ana_port_i(pins[23:16]), .ana_port_o(an_o),
    .ana_port_oe_o(an_oe), .ana_port_pullup_o(an_pu));
  wfp_wake_pins i_pins (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .hold_i(hold),
    .pin_n_o(pins_n));
  // ---------------------------------------------
  // Clock, helpers and bus tasks
  // ---------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Writing 0 clears a flag, writing 1 leaves it alone
  function automatic logic [31:0] exp_clear(input logic [7:0] f, input logic [7:0] v);
    return {24'h0, f & v};
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Classic cycle: hold until ack, take data there, then release
  task automatic bus(input logic w_en, input logic [7:0] a, input logic [31:0] dv);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_en;
    adr <= a;
    wdat <= dv;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      end_sim();
    end
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask
  task automatic mode(input wfp_pkg::wfp_pmode_type md);
    @(posedge clk_i);
    pm <= md;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic pulse(input logic [7:0] mask);
    @(posedge clk_i);
    fire <= mask;
    hold <= 3'h2 + 3'(seed[18:16] % 6);
    @(posedge clk_i);
    fire <= 8'h00;
    repeat (12) @(posedge clk_i);
  endtask
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    {rst_i, cyc, stb, we, slp, dtm, adr, fire, wdat, pins} = '0;
    rst_i = 1'b1;
    sel = 4'hF;
    hold = 3'h2;
    seed = 32'h8CB9;
    pm = wfp_pkg::PM_ACTIVE;
    miscompares = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk_i);
    chk("oe_rst", {8'h0, pu_oe, pl_oe, an_oe}, 32'h0);
    rst_i <= 1'b0;
    rdchk("wake_rst", 8'h00, 32'h0);
    bus(1'b1, 8'h04, 32'hFF);
    bus(1'b1, 8'h18, 32'h1FF);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      m = seed[7:0] | 8'h01;
      w = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed[15:8];
      pulse(m);
      rdchk("flags", 8'h00, {24'h0, m});
      chk("irq_set", 32'(irq), 32'h1);
      chk("wake_req", 32'(wreq), 32'h1);
      bus(1'b1, 8'h00, {24'h0, w});
      rdchk("flags_clr", 8'h00, exp_clear(m, w));
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h14, 32'h1FF);
      // The clear lands on the ack edge; look once it has settled
      @(posedge clk_i);
      chk("irq_clr", 32'(irq), 32'h0);
    end
    $display("test wakeup done");
    bus(1'b1, 8'h18, 32'h0);
    pulse(8'h80);
    chk("irq_mask", 32'(irq), 32'h0);
    rdchk("int_stat", 8'h10, 32'h80);
    bus(1'b1, 8'h14, 32'h1FF);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, 8'h08, 32'(k != 0));
      @(posedge clk_i);
      chk("dt_en", 32'(dte), 32'(k != 0));
      @(posedge clk_i);
      slp <= 1'b1;
      dtm <= (k != 1);
      @(posedge clk_i);
      {slp, dtm} <= 2'b00;
      rdchk("dt_flag", 8'h0C, 32'(k == 2));
      bus(1'b1, 8'h0C, 32'h0);
    end
    rdchk("int_dt", 8'h10, 32'h100);
    rdchk("unmapped", 8'hFC, 32'h0);
    $display("test transfer done");
    seed = lfsr(seed);
    {p, r, d} = seed[23:0];
    pins <= seed[23:0];
    bus(1'b1, 8'h30, {24'h0, d});
    bus(1'b1, 8'h34, {24'h0, r});
    bus(1'b1, 8'h38, {24'h0, p});
    bus(1'b1, 8'h44, {24'h0, r});
    bus(1'b1, 8'h28, {24'h0, p});
    mode(wfp_pkg::PM_ACTIVE);
    chk("act_oe", {pl_oe, an_oe}, {r, r});
    chk("act_out", pl_o & r, d & r);
    chk("act_pu", {pu_pu, pl_pu}, {p, p & ~r});
    rdchk("pin_lvl", 8'h3C, {24'h0, r});
    mode(wfp_pkg::PM_SLEEP);
    bus(1'b1, 8'h30, {24'h0, ~d});
    chk("slp_hold", {pl_oe, pl_o & r}, {r, d & r});
    mode(wfp_pkg::PM_SUBSLEEP);
    rdchk("pmode", 8'h1C, 32'h3);
    chk("subslp_hold", {pl_oe, pl_o & r}, {r, d & r});
    mode(wfp_pkg::PM_WATCH);
    chk("watch_hold", {pl_oe, pl_o & r}, {r, d & r});
    mode(wfp_pkg::PM_SUBACTIVE);
    chk("sub_ana", {an_oe, pl_o & r}, {8'h00, ~d & r});
    mode(wfp_pkg::PM_STANDBY);
    chk("stb_float", {pl_oe, an_oe}, 16'h0);
    chk("stb_pull", {pu_oe, pu_o & p}, {p, p});
    mode(wfp_pkg::PM_ACTIVE);
    $display("test ports done");
    end_sim();
  end
endmodule
